// *** hdl/acq_trig_pkg.sv ***
// shared constants and types for the acquisition trigger sequencer
package acq_trig_pkg;

    // trigger source selector codes
    localparam logic [1:0] SRC_TERMINAL = 2'h0;  // programmable function terminal
    localparam logic [1:0] SRC_COUNTER  = 2'h1;  // timer unit output
    localparam logic [1:0] SRC_INTERNAL = 2'h2;  // other internal signal
    localparam logic [1:0] SRC_ANALOG   = 2'h3;  // analog comparison event

    // sequencer states, gray coded along idle->delay->pre->arm->post
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_DELAY = 3'b001,
        ST_PRE   = 3'b011,
        ST_ARMED = 3'b010,
        ST_POST  = 3'b110
    } acq_state_t;

    // one trigger's selection
    typedef struct packed {
        logic       enable;     // trigger in use
        logic [1:0] source;     // source code
        logic [2:0] term_sel;   // terminal index
        logic       falling;    // edge or active-low level
    } trig_cfg_t;

    // acquisition configuration
    typedef struct packed {
        logic        finite;     // finite or continuous
        logic [23:0] total;      // sample count or buffer size
        logic [23:0] pretrig;    // pretrigger samples
        logic [23:0] start_dly;  // pacing ticks before first sample
        logic [23:0] pace_div;   // core cycles per pacing tick
    } acq_cfg_t;

    localparam logic [23:0] CNT_ZERO = 24'h00_0000;
    localparam logic [23:0] CNT_ONE  = 24'h00_0001;
    localparam int          SYNC_STAGES = 2;

endpackage : acq_trig_pkg

// *** hdl/acq_trigger_control.sv ***
// trigger sequencer for an analog acquisition timing engine
`timescale 1ns/10ps
`default_nettype none

// How it works
// - begin on trigger, else software command
// - finite by count or trigger; continuous by stop
// - without end trigger, record only after begin
// - programmable delay begin to first sample
// - begin source and edge selectable
// - analog begin uses first rising edge
// - begin trigger routed out, active-high pulse
// - posttrigger count is buffer minus pretrigger
// - end trigger ignored before pretrigger count
// - full buffer overwrites oldest sample circularly
// - after end trigger finish posttrigger count
// - end source and edge selectable
// - analog end uses configured edge
// - end trigger routed out, active-high default
// - hold trigger stops pacing clock while active
// - hold active level programmable
// - analog hold gates on event level
// - hold is level sensitive only
// - each pacing pulse starts one sample
module acq_trigger_control
    import acq_trig_pkg::*;
#(
    parameter int NUM_TERM = 8,     // programmable function terminals
    parameter int ADDR_W   = 24     // buffer address width
) (
    input  wire logic                core_clk,
    input  wire logic                rst_n,
    input  wire logic [NUM_TERM-1:0] programmable_function_terminal,
    input  wire logic                counter_out,
    input  wire logic                internal_sig,
    input  wire logic                analog_event,
    input  wire trig_cfg_t           begin_cfg,
    input  wire trig_cfg_t           end_cfg,
    input  wire trig_cfg_t           hold_cfg,
    input  wire acq_cfg_t            acq_cfg,
    input  wire logic                sw_start,
    input  wire logic                sw_stop,
    input  wire logic                route_end_invert,
    output logic                     acq_begin_trigger,
    output logic                     end_trigger_out,
    output logic                     sample_pacing_clock,
    output logic [ADDR_W-1:0]        write_addr,
    output logic                     running,
    output logic                     triggered,
    output logic                     done
);

    // raw source vector: terminals, counter, internal, analog
    localparam int NSRC = NUM_TERM + 3;
    logic [NSRC-1:0] raw_src;
    logic [NSRC-1:0] sync_a;     // first stage, read only by sync_b
    logic [NSRC-1:0] sync_b;     // usable synchronised level
    logic [NSRC-1:0] sync_d;     // delayed for edge detection

    assign raw_src = {analog_event, internal_sig, counter_out, programmable_function_terminal};

    // two-stage synchronisers, one per source
    // a source already high at release shows one rising edge; enable after it settles
    genvar gi;
    generate
        for (gi = 0; gi < NSRC; gi++) begin : g_sync
            always_ff @(posedge core_clk) begin
                if (!rst_n) begin
                    sync_a[gi] <= 1'b0;
                    sync_b[gi] <= 1'b0;
                    sync_d[gi] <= 1'b0;
                end else begin
                    sync_a[gi] <= raw_src[gi];
                    sync_b[gi] <= sync_a[gi];
                    sync_d[gi] <= sync_b[gi];
                end
            end
        end
    endgenerate

    // pick the synchronised level for one trigger
    function automatic logic pick_level(input trig_cfg_t c, input logic [NSRC-1:0] v);
        logic r;
        r = 1'b0;
        // the terminal index only matters for the terminal source
        case (c.source)
            SRC_TERMINAL: r = v[c.term_sel];
            SRC_COUNTER:  r = v[NUM_TERM];
            SRC_INTERNAL: r = v[NUM_TERM+1];
            SRC_ANALOG:   r = v[NUM_TERM+2];
            default:      r = 1'b0;
        endcase
        return r;
    endfunction

    // synchronised level now and one cycle ago for begin and end; hold uses the level now only
    logic begin_now, begin_old, end_now, end_old, hold_lvl;
    logic begin_edge, end_edge, hold_active;
    logic begin_fall, end_fall;

    assign begin_now = pick_level(begin_cfg, sync_b);
    assign begin_old = pick_level(begin_cfg, sync_d);
    assign end_now   = pick_level(end_cfg, sync_b);
    assign end_old   = pick_level(end_cfg, sync_d);
    assign hold_lvl  = pick_level(hold_cfg, sync_b);

    // analog begin always fires on rising edge
    assign begin_fall = (begin_cfg.source == SRC_ANALOG) ? 1'b0 : begin_cfg.falling;
    assign end_fall   = end_cfg.falling;
    // one pulse per qualifying edge
    assign begin_edge = begin_fall ? (begin_old & ~begin_now)
                                   : (~begin_old & begin_now);
    assign end_edge   = end_fall ? (end_old & ~end_now) : (~end_old & end_now);
    // level only; polarity programmable for every source
    assign hold_active = hold_cfg.enable & (hold_lvl ^ hold_cfg.falling);

    acq_state_t  state;
    logic [23:0] pace_cnt;      // divider for the pacing clock
    logic        pace_tick;     // free-running pacing tick
    logic [23:0] dly_cnt;       // start delay count
    logic [23:0] smp_cnt;       // samples taken in current phase
    logic [23:0] post_target;   // posttrigger samples
    logic        go;            // begin event in idle
    logic        sample;        // sample taken this cycle
    logic        capture_phase;

    assign pace_tick = (pace_cnt == CNT_ZERO);
    // posttrigger length is buffer size minus pretrigger
    assign post_target = acq_cfg.total - acq_cfg.pretrig;
    assign go = (state == ST_IDLE) &&
                (begin_cfg.enable ? begin_edge : sw_start);
    assign capture_phase = (state == ST_PRE) || (state == ST_ARMED) || (state == ST_POST);
    // pacing pulse is gated while hold is active; no sample before begin
    assign sample = capture_phase && pace_tick && !hold_active;

    // pacing divider runs free so hold release resumes on next tick
    // trade-off: the first sample may wait up to one divider period
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pace_cnt <= CNT_ZERO;
        end else if (pace_tick) begin
            pace_cnt <= (acq_cfg.pace_div == CNT_ZERO) ? CNT_ZERO
                                                       : acq_cfg.pace_div - CNT_ONE;
        end else begin
            pace_cnt <= pace_cnt - CNT_ONE;
        end
    end

    // main sequencer
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state   <= ST_IDLE;
            dly_cnt <= CNT_ZERO;
            smp_cnt <= CNT_ZERO;
            done    <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    // starts arriving while busy never reach here
                    if (go) begin
                        done    <= 1'b0;
                        smp_cnt <= CNT_ZERO;
                        dly_cnt <= acq_cfg.start_dly;
                        state   <= (acq_cfg.start_dly == CNT_ZERO) ? ST_PRE : ST_DELAY;
                    end
                end
                ST_DELAY: begin
                    // delay counted in pacing ticks; a continuous run may stop here
                    if (!acq_cfg.finite && sw_stop) begin
                        state <= ST_IDLE;
                        done  <= 1'b1;
                    end else if (pace_tick) begin
                        if (dly_cnt == CNT_ONE) begin
                            state <= ST_PRE;
                        end
                        dly_cnt <= dly_cnt - CNT_ONE;
                    end
                end
                ST_PRE: begin
                    // pretrigger phase, or the whole capture without an end trigger
                    if (sample) begin
                        smp_cnt <= smp_cnt + CNT_ONE;
                    end
                    if (!acq_cfg.finite) begin
                        // continuous: stop on software only
                        if (sw_stop) begin
                            state <= ST_IDLE;
                            done  <= 1'b1;
                        end
                    end else if (end_cfg.enable) begin
                        // arm only after pretrigger samples are in
                        if (smp_cnt + (sample ? CNT_ONE : CNT_ZERO) >= acq_cfg.pretrig) begin
                            state <= ST_ARMED;
                        end
                    end else if (sample && smp_cnt + CNT_ONE >= acq_cfg.total) begin
                        state <= ST_IDLE;
                        done  <= 1'b1;
                    end
                end
                ST_ARMED: begin
                    // samples keep wrapping while waiting
                    if (end_edge) begin
                        smp_cnt <= CNT_ZERO;
                        if (post_target == CNT_ZERO) begin
                            state <= ST_IDLE;
                            done  <= 1'b1;
                        end else begin
                            state <= ST_POST;
                        end
                    end
                end
                ST_POST: begin
                    // posttrigger samples, then done
                    if (sample) begin
                        smp_cnt <= smp_cnt + CNT_ONE;
                        if (smp_cnt + CNT_ONE >= post_target) begin
                            state <= ST_IDLE;
                            done  <= 1'b1;
                        end
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // circular write pointer over the finite buffer
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            write_addr <= '0;
        end else if (go) begin
            // every start restarts the buffer at zero
            write_addr <= '0;
        end else if (sample) begin
            if (acq_cfg.finite && write_addr + 1'b1 >= acq_cfg.total[ADDR_W-1:0]) begin
                write_addr <= '0;
            end else begin
                write_addr <= write_addr + 1'b1;
            end
        end
    end

    // registered outputs
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            acq_begin_trigger   <= 1'b0;
            end_trigger_out     <= 1'b0;
            sample_pacing_clock <= 1'b0;
            running             <= 1'b0;
            triggered           <= 1'b0;
        end else begin
            acq_begin_trigger   <= go;
            // routed end pulse, active high unless inverted
            end_trigger_out     <= ((state == ST_ARMED) && end_edge) ^ route_end_invert;
            // one pulse per sample, never while held
            sample_pacing_clock <= sample;
            // high from the start pulse until back in idle
            running             <= (state != ST_IDLE) && !go ? 1'b1 : go;
            triggered           <= (state == ST_POST);
        end
    end

    // guards on the sequencer, all on the core clock
    // a pretrigger phase never jumps straight to posttrigger
    a_end_ignored_pre: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state == ST_PRE) |=> (state != ST_POST)) else $error("end trigger taken early");
    // arming needs the full pretrigger count
    a_armed_pretrig: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state == ST_ARMED) |-> (smp_cnt >= acq_cfg.pretrig)) else $error("armed too soon");
    // held pacing produces no sample pulse
    a_hold_blocks: assert property (@(posedge core_clk) disable iff (!rst_n)
        hold_active |=> !sample_pacing_clock) else $error("sample during hold");
    // start pulse lasts exactly one cycle
    a_begin_pulse: assert property (@(posedge core_clk) disable iff (!rst_n)
        go |=> acq_begin_trigger ##1 !acq_begin_trigger) else $error("begin pulse bad");
    // nothing sampled before the begin event
    a_idle_no_sample: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state == ST_IDLE) |-> !sample) else $error("sample before begin");
    // posttrigger counter stays below its target
    a_post_count: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state == ST_POST) |-> (smp_cnt < post_target)) else $error("post overrun");
    // a qualifying edge gives a single pulse
    a_edge_single: assert property (@(posedge core_clk) disable iff (!rst_n)
        begin_edge |=> !begin_edge) else $error("double edge pulse");
    // start delay holds off the first sample
    a_delay_first: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state == ST_DELAY) |-> !sample) else $error("sample in delay");
    // software stop ends a continuous run at once
    a_cont_stop: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state == ST_PRE && !acq_cfg.finite && sw_stop) |=> (state == ST_IDLE && done))
        else $error("stop ignored");
    // plain finite capture never exceeds its count
    a_finite_count: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state == ST_PRE && acq_cfg.finite && !end_cfg.enable && acq_cfg.total != CNT_ZERO)
        |-> (smp_cnt < acq_cfg.total)) else $error("finite overrun");
    // finite pointer wraps inside the buffer
    a_addr_wrap: assert property (@(posedge core_clk) disable iff (!rst_n)
        (acq_cfg.finite && sample_pacing_clock && acq_cfg.total != CNT_ZERO)
        |-> (write_addr < acq_cfg.total[ADDR_W-1:0])) else $error("pointer past buffer");
    // accepted end edge shows on the routed output
    a_end_route: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state == ST_ARMED && end_edge) |=> (end_trigger_out != $past(route_end_invert)))
        else $error("end pulse missing");

endmodule : acq_trigger_control

`default_nettype wire

// *** testbench/acq_trig_source_model.sv ***
// behavioural model of the trigger terminals and internal trigger sources
`timescale 1ns/10ps
`default_nettype none
module acq_trig_source_model
    import acq_trig_pkg::*;
(
    input  wire logic       core_clk,
    output logic      [7:0] term_pins,
    output logic            counter_line,
    output logic            internal_line,
    output logic            analog_line
);
    // all sources idle low until a scenario moves them
    initial begin
        term_pins     = 8'h00;
        counter_line  = 1'b0;
        internal_line = 1'b0;
        analog_line   = 1'b0;
    end

    // levels change just after an edge, never on it, to keep sampling race free
    task automatic drive(input logic [1:0] src, input logic [2:0] sel, input logic lvl);
        @(posedge core_clk);
        #1;
        case (src)
            SRC_TERMINAL: term_pins[sel] = lvl;
            SRC_COUNTER:  counter_line = lvl;
            SRC_INTERNAL: internal_line = lvl;
            default:      analog_line = lvl;
        endcase
    endtask : drive
endmodule : acq_trig_source_model
`default_nettype wire

// *** testbench/acq_trigger_control_tb_top.sv ***
// self-checking bench for the acquisition trigger sequencer
`timescale 1ns/10ps
`default_nettype none
module acq_trigger_control_tb_top;
    import acq_trig_pkg::*;
    logic        core_clk, rst_n, sw_start, sw_stop;
    logic [7:0]  pins;
    logic        cnt_l, int_l, ana_l, f, inv;
    trig_cfg_t   begin_cfg, end_cfg, hold_cfg;
    acq_cfg_t    acq_cfg;
    logic        bt, et, spc, running, triggered, done, done_q;
    logic [23:0] write_addr;
    logic [1:0]  s;
    logic [2:0]  sel;
    logic [31:0] exp_q[$];  // {end pulses, samples counted since begin or end pulse}
    logic [31:0] e;
    int          n_errors, tests_run, n_samp, n_end, cycles, seed, k;

    // free running 125 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    acq_trig_source_model src_u (.core_clk(core_clk), .term_pins(pins),
        .counter_line(cnt_l), .internal_line(int_l), .analog_line(ana_l));

    acq_trigger_control dut_u (.core_clk(core_clk), .rst_n(rst_n),
        .programmable_function_terminal(pins), .counter_out(cnt_l), .internal_sig(int_l),
        .analog_event(ana_l), .begin_cfg(begin_cfg), .end_cfg(end_cfg), .hold_cfg(hold_cfg),
        .acq_cfg(acq_cfg), .sw_start(sw_start), .sw_stop(sw_stop), .route_end_invert(inv),
        .acq_begin_trigger(bt), .end_trigger_out(et), .sample_pacing_clock(spc),
        .write_addr(write_addr), .running(running), .triggered(triggered), .done(done));

    // one comparison, counted; mismatches reported at once
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : cyc

    task automatic go_sw();
        sw_start = 1'b1;
        cyc(1);
        sw_start = 1'b0;
    endtask : go_sw

    // bounded wait for completion
    task automatic wait_done();
        cyc(3);
        k = 0;
        while (done !== 1'b1 && k < 3000) begin
            cyc(1);
            k++;
        end
        chk("done", {31'h0, done}, 32'h0000_0001);
        cyc(2);
    endtask : wait_done

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : wrap_up

    // output watcher: counts samples and end pulses, compares at each completion that has an expectation queued
    always @(posedge core_clk) begin
        if (rst_n === 1'b1) begin
            if (bt === 1'b1) begin
                n_samp = 0;
                n_end = 0;
            end
            if (spc === 1'b1) begin
                n_samp++;
                if (end_cfg.enable) chk("write_addr", {31'h0, write_addr < acq_cfg.total}, 1);
            end
            // a sample launched with the end pulse is still a pretrigger one
            if (et === 1'b1) begin
                n_end++;
                n_samp = 0;
            end
            if (done === 1'b1 && done_q !== 1'b1 && exp_q.size() > 0) begin
                e = exp_q.pop_front();
                chk("samples", n_samp, {8'h00, e[23:0]});
                chk("end pulses", n_end, {24'h00_0000, e[31:24]});
            end
        end
        done_q = done;
    end

    // hang guard
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 40000) begin
            n_errors++;
            wrap_up();
        end
    end

    initial begin
        seed = 32'h3259_8690;
        rst_n = 1'b0;
        sw_start = 1'b0;
        sw_stop = 1'b0;
        begin_cfg = '0;
        end_cfg = '0;
        hold_cfg = '0;
        inv = 1'b0;
        acq_cfg = '{1'b1, 24'h00_0005, 24'h00_0000, 24'h00_0000, 24'h00_0000};
        n_errors = 0;
        tests_run = 0;
        cycles = 0;
        cyc(5);
        rst_n = 1'b1;
        cyc(2);
        // software start, finite count, random size and pacing
        for (int i = 0; i < 3; i++) begin
            acq_cfg.total = 24'h00_0003 + 24'($unsigned($random(seed)) % 4);
            acq_cfg.pace_div = 24'($unsigned($random(seed)) % 4);
            exp_q.push_back({8'h00, acq_cfg.total});
            go_sw();
            wait_done();
        end
        $display("test software start finished");
        // edge start from every source and edge, with a start delay
        acq_cfg.start_dly = 24'h00_0003;
        acq_cfg.pace_div = 24'h00_0002;
        for (int i = 0; i < 8; i++) begin
            s = i[2:1];
            f = i[0];
            sel = 3'($random(seed));
            src_u.drive(s, sel, f);
            cyc(4);
            begin_cfg = '{1'b1, s, sel, f};
            cyc(4);
            chk("running", {31'h0, running}, 0);
            src_u.drive(s, sel, ~f);
            cyc(6);
            // analog begin ignores the falling selection, so only a rise starts it
            if (s == SRC_ANALOG && f) begin
                chk("running", {31'h0, running}, 0);
                src_u.drive(s, sel, f);
            end
            exp_q.push_back({8'h00, acq_cfg.total});
            wait_done();
            begin_cfg.enable = 1'b0;
            src_u.drive(s, sel, 1'b0);
        end
        $display("test edge start finished");
        // end-of-capture trigger, early edge ignored, buffer wraps
        acq_cfg = '{1'b1, 24'h00_0008, 24'h00_0003, 24'h00_0000, 24'h00_0008};
        for (int i = 0; i < 2; i++) begin
            s = i[0] ? SRC_ANALOG : SRC_INTERNAL;
            f = i[0];
            // idle at the level before the configured edge
            src_u.drive(s, 3'h0, f);
            cyc(4);
            end_cfg = '{1'b1, s, 3'h0, f};
            exp_q.push_back({8'h01, 24'h00_0005});
            go_sw();
            // qualifying edge before the pretrigger count is in
            src_u.drive(s, 3'h0, ~f);
            src_u.drive(s, 3'h0, f);
            k = 0;
            while (n_samp < 6 && k < 500) begin
                cyc(1);
                k++;
            end
            chk("early end", n_end, 0);
            chk("triggered", {31'h0, triggered}, 0);
            src_u.drive(s, 3'h0, ~f);
            cyc(6);
            chk("triggered", {31'h0, triggered}, 1);
            wait_done();
            end_cfg.enable = 1'b0;
        end
        $display("test end trigger finished");
        // hold trigger: pin active high, then analog active low
        acq_cfg = '{1'b1, 24'h00_0004, 24'h00_0000, 24'h00_0000, 24'h00_0001};
        for (int i = 0; i < 2; i++) begin
            s = i[0] ? SRC_ANALOG : SRC_TERMINAL;
            f = i[0];
            hold_cfg = '{1'b1, s, 3'h5, f};
            src_u.drive(s, 3'h5, ~f);
            cyc(4);
            go_sw();
            cyc(30);
            chk("held samples", n_samp, 0);
            exp_q.push_back({8'h00, 24'h00_0004});
            src_u.drive(s, 3'h5, f);
            wait_done();
            hold_cfg.enable = 1'b0;
        end
        $display("test hold finished");
        // routed end output inverts while idle when asked
        inv = 1'b1;
        cyc(2);
        chk("end route", {31'h0, et}, 1);
        inv = 1'b0;
        cyc(2);
        // continuous run ends only on the stop command
        acq_cfg.finite = 1'b0;
        go_sw();
        cyc(40);
        chk("running", {31'h0, running}, 1);
        sw_stop = 1'b1;
        cyc(1);
        sw_stop = 1'b0;
        cyc(6);
        chk("running", {31'h0, running}, 0);
        $display("test continuous finished");
        wrap_up();
    end
endmodule : acq_trigger_control_tb_top
`default_nettype wire
